// File: design/vecm_consts.svh
`ifndef VECM_CONSTS_SVH
`define VECM_CONSTS_SVH

// ==========================================================================
// Register map.
`define VM_ADDR_W        7
`define VM_ADDR_CFG      7'h5F
`define VM_ADDR_THS_HI   7'h60
`define VM_ADDR_THS_LO   7'h61
`define VM_ADDR_CNT      7'h62
`define VM_ADDR_INITX_HI 7'h63
`define VM_ADDR_INITX_LO 7'h64
`define VM_ADDR_INITY_HI 7'h65
`define VM_ADDR_INITY_LO 7'h66
`define VM_ADDR_INITZ_HI 7'h67
`define VM_ADDR_INITZ_LO 7'h68

// ==========================================================================
// Field positions and constants.
`define VM_CFG_ELE       6
`define VM_CFG_INITM     5
`define VM_CFG_UPDM      4
`define VM_CFG_EN        3
`define VM_THS_DBCNTM    7
`define VM_BYTE_ZERO     8'h00
`define VM_CNT_ONE       8'h01
`define VM_AXIS_X        0
`define VM_AXIS_Y        1
`define VM_AXIS_Z        2

`endif

// File: design/vecm_pkg.sv
package vecm_pkg;

  // ========================================================================
  // Types.
  typedef logic signed [13:0] accel_t;
  typedef logic [29:0]        sq_t;
  typedef logic [31:0]        mag_t;

  typedef struct packed {
    logic                 ele;
    logic                 initm;
    logic                 updm;
    logic                 en;
    logic                 en_d;
    logic                 dbcntm;
    logic [12:0]          ths;
    logic [7:0]           cnt;
    logic [2:0][13:0]     init;
    logic [2:0][13:0]     refv;
    logic [7:0]           dbc;
    logic                 cond;
    logic                 latch;
    logic                 flag;
    logic [7:0]           rd_data;
  } state_s;

endpackage

// File: design/vecm_axis_sq.sv
`timescale 1ns/100ps

module vecm_axis_sq
  import vecm_pkg::*;
(
  // Axis values.
  input  wire accel_t sample_i,
  input  wire accel_t reference_i,
  // Squared difference.
  output sq_t         sq_o
);

  logic signed [14:0] diff;
  logic signed [29:0] prod;

  // ========================================================================
  // Square of the per-axis difference.
  always_comb begin
    diff = 15'(sample_i) - 15'(reference_i);
    prod = 30'(diff) * 30'(diff);
    sq_o = sq_t'(prod);
  end

endmodule

// File: design/vecm_detector.sv
`timescale 1ns/100ps
`include "vecm_consts.svh"

module vecm_detector
  import vecm_pkg::*;
(
  // Clock and reset.
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  // Register port.
  input  wire logic [`VM_ADDR_W-1:0] reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_rd_i,
  output logic      [7:0]            reg_rdata_o,
  input  wire logic                  int_src_read_i,
  // Acceleration samples.
  input  wire logic                  sample_valid_i,
  input  wire accel_t                accel_x_i,
  input  wire accel_t                accel_y_i,
  input  wire accel_t                accel_z_i,
  // Event output.
  output logic                       vecm_event_o
);

  state_s             st_r;
  state_s             st_nxt;
  accel_t             acc     [3];
  sq_t                sq      [3];
  mag_t               mag;
  mag_t               ths_sq;
  logic               above;
  logic               run;
  logic               en_rise;
  logic               met;
  logic [7:0]         dbc_step;

  assign acc[`VM_AXIS_X] = accel_x_i;
  assign acc[`VM_AXIS_Y] = accel_y_i;
  assign acc[`VM_AXIS_Z] = accel_z_i;

  // ========================================================================
  // Per-axis squared differences.
  // Difference per axis.
  for (genvar a = 0; a < 3; a++) begin : g_axis
    vecm_axis_sq u_sq (
      .sample_i    (acc[a]),
      .reference_i (accel_t'(st_r.refv[a])),
      .sq_o        (sq[a])
    );
  end

  // ========================================================================
  // Next-state logic.
  always_comb begin
    st_nxt   = st_r;
    mag      = mag_t'(sq[0]) + mag_t'(sq[1]) + mag_t'(sq[2]);
    ths_sq   = mag_t'(26'(st_r.ths) * 26'(st_r.ths));
    above    = mag > ths_sq;
    en_rise  = st_r.en && !st_r.en_d;
    run      = st_r.en && st_r.en_d && sample_valid_i;
    met      = 1'b0;
    dbc_step = st_r.dbc;
    st_nxt.en_d = st_r.en;
    if (!st_r.en) begin
      st_nxt.dbc  = `VM_BYTE_ZERO;
      st_nxt.cond = 1'b0;
    end
    if (en_rise) begin
      st_nxt.dbc = `VM_BYTE_ZERO;
      for (int a = 0; a < 3; a++) begin
        st_nxt.refv[a] = st_r.initm ? st_r.init[a] : acc[a];
      end
    end
    if (st_r.en && st_r.initm && st_r.updm) begin
      st_nxt.refv = st_r.init;
    end
    if (run) begin
      if (above) begin
        if (st_r.dbc < st_r.cnt) begin
          dbc_step = st_r.dbc + `VM_CNT_ONE;
        end else begin
          dbc_step = st_r.cnt;
        end
        met = (dbc_step == st_r.cnt);
      end else if (st_r.dbcntm) begin
        dbc_step = `VM_BYTE_ZERO;
      end else if (st_r.dbc != `VM_BYTE_ZERO) begin
        dbc_step = st_r.dbc - `VM_CNT_ONE;
      end
      st_nxt.dbc  = dbc_step;
      st_nxt.cond = met;
      if (met && !st_r.updm) begin
        for (int a = 0; a < 3; a++) begin
          st_nxt.refv[a] = acc[a];
        end
      end
    end
    // Latch clear by source read; a new event wins.
    if (int_src_read_i) begin
      st_nxt.latch = 1'b0;
    end
    if (met) begin
      st_nxt.latch = 1'b1;
    end
    // Register writes.
    if (reg_wr_i) begin
      case (reg_addr_i)
        `VM_ADDR_CFG: begin
          st_nxt.ele   = reg_wdata_i[`VM_CFG_ELE];
          st_nxt.initm = reg_wdata_i[`VM_CFG_INITM];
          st_nxt.updm  = reg_wdata_i[`VM_CFG_UPDM];
          st_nxt.en    = reg_wdata_i[`VM_CFG_EN];
        end
        // Threshold high part and debounce mode.
        `VM_ADDR_THS_HI: begin
          st_nxt.dbcntm     = reg_wdata_i[`VM_THS_DBCNTM];
          st_nxt.ths[12:8]  = reg_wdata_i[4:0];
        end
        `VM_ADDR_THS_LO:   st_nxt.ths[7:0] = reg_wdata_i;
        `VM_ADDR_CNT:      st_nxt.cnt      = reg_wdata_i;
        `VM_ADDR_INITX_HI: st_nxt.init[`VM_AXIS_X][13:8] = reg_wdata_i[5:0];
        `VM_ADDR_INITX_LO: st_nxt.init[`VM_AXIS_X][7:0]  = reg_wdata_i;
        `VM_ADDR_INITY_HI: st_nxt.init[`VM_AXIS_Y][13:8] = reg_wdata_i[5:0];
        `VM_ADDR_INITY_LO: st_nxt.init[`VM_AXIS_Y][7:0]  = reg_wdata_i;
        `VM_ADDR_INITZ_HI: st_nxt.init[`VM_AXIS_Z][13:8] = reg_wdata_i[5:0];
        `VM_ADDR_INITZ_LO: st_nxt.init[`VM_AXIS_Z][7:0]  = reg_wdata_i;
        default: begin
        end
      endcase
    end
    // Read mux without the working references.
    if (reg_rd_i) begin
      case (reg_addr_i)
        `VM_ADDR_CFG: begin
          st_nxt.rd_data                = `VM_BYTE_ZERO;
          st_nxt.rd_data[`VM_CFG_ELE]   = st_r.ele;
          st_nxt.rd_data[`VM_CFG_INITM] = st_r.initm;
          st_nxt.rd_data[`VM_CFG_UPDM]  = st_r.updm;
          st_nxt.rd_data[`VM_CFG_EN]    = st_r.en;
        end
        `VM_ADDR_THS_HI:   st_nxt.rd_data = {st_r.dbcntm, 2'b00, st_r.ths[12:8]};
        `VM_ADDR_THS_LO:   st_nxt.rd_data = st_r.ths[7:0];
        `VM_ADDR_CNT:      st_nxt.rd_data = st_r.cnt;
        `VM_ADDR_INITX_HI: st_nxt.rd_data = {2'b00, st_r.init[`VM_AXIS_X][13:8]};
        `VM_ADDR_INITX_LO: st_nxt.rd_data = st_r.init[`VM_AXIS_X][7:0];
        `VM_ADDR_INITY_HI: st_nxt.rd_data = {2'b00, st_r.init[`VM_AXIS_Y][13:8]};
        `VM_ADDR_INITY_LO: st_nxt.rd_data = st_r.init[`VM_AXIS_Y][7:0];
        `VM_ADDR_INITZ_HI: st_nxt.rd_data = {2'b00, st_r.init[`VM_AXIS_Z][13:8]};
        `VM_ADDR_INITZ_LO: st_nxt.rd_data = st_r.init[`VM_AXIS_Z][7:0];
        default:           st_nxt.rd_data = `VM_BYTE_ZERO;
      endcase
    end
    st_nxt.flag = st_nxt.ele ? st_nxt.latch : st_nxt.cond;
  end

  // ========================================================================
  // State register.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o  = st_r.rd_data;
  assign vecm_event_o = st_r.flag;

  // ========================================================================
  // Assertions.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence seq_enable_rise;
    st_r.en && !st_r.en_d;
  endsequence

  sequence seq_sample_run;
    st_r.en && st_r.en_d && sample_valid_i;
  endsequence

  a_capture_ref: assert property (seq_enable_rise and !st_r.initm |=>
    st_r.refv == $past({accel_z_i, accel_y_i, accel_x_i}))
    else $error("Reference not captured from outputs at enable.");

  a_init_ref: assert property (seq_enable_rise and st_r.initm |=>
    st_r.refv == $past(st_r.init))
    else $error("Reference not loaded from initial registers.");

  a_trig_update: assert property (met && !st_r.updm && st_r.en |=>
    st_r.refv == $past({accel_z_i, accel_y_i, accel_x_i}))
    else $error("Reference not updated on trigger.");

  a_ref_hold: assert property (st_r.en && st_r.en_d && st_r.updm && !st_r.initm |=>
    $stable(st_r.refv))
    else $error("Reference changed while update mode holds it.");

  a_live_ref: assert property (st_r.en && st_r.initm && st_r.updm |=>
    st_r.refv == $past(st_r.init))
    else $error("Live reference does not follow initial registers.");

  a_idle_off: assert property (!st_r.en |=> !st_r.cond && st_r.dbc == 8'h00)
    else $error("Detector active while disabled.");

  a_dbc_decr: assert property (seq_sample_run ##0 (!above && !st_r.dbcntm
    && st_r.dbc != 8'h00) |=> st_r.dbc == $past(st_r.dbc) - 8'h01)
    else $error("Debounce counter not decremented.");

  a_dbc_clear: assert property (seq_sample_run ##0 (!above && st_r.dbcntm)
    |=> st_r.dbc == 8'h00)
    else $error("Debounce counter not cleared.");

  a_dbc_count: assert property (seq_sample_run ##0 (above && st_r.dbc < st_r.cnt)
    |=> st_r.dbc == $past(st_r.dbc) + 8'h01 && st_r.cond == (st_r.dbc == $past(st_r.cnt)))
    else $error("Debounce counter did not count up.");

  a_dbc_sat: assert property (seq_sample_run ##0 (above && st_r.dbc >= st_r.cnt)
    |=> st_r.dbc == $past(st_r.cnt) && st_r.cond)
    else $error("Saturated debounce counter did not hold the condition.");

  a_latch_hold: assert property (st_r.ele && st_r.flag && !int_src_read_i
    |=> st_r.flag || !st_r.ele)
    else $error("Latched flag dropped without source read.");

endmodule

// File: verification/tb.sv
`timescale 1ns/100ps
`include "vecm_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

// ==========================================================================
// Register and sample sequences against the change detector.
module tb
  import vecm_pkg::*;
;
  logic       ref_clk_i;
  logic       reset_i;
  logic [6:0] reg_addr_i;
  logic       reg_wr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic       int_src_read_i;
  logic       sample_valid_i;
  accel_t     accel_x_i;
  accel_t     accel_y_i;
  accel_t     accel_z_i;
  logic       vecm_event_o;
  int         error_cnt;
  int         samples_checked;

  vecm_detector vecm_detector_i (
    .ref_clk_i      (ref_clk_i),
    .reset_i        (reset_i),
    .reg_addr_i     (reg_addr_i),
    .reg_wr_i       (reg_wr_i),
    .reg_wdata_i    (reg_wdata_i),
    .reg_rd_i       (reg_rd_i),
    .reg_rdata_o    (reg_rdata_o),
    .int_src_read_i (int_src_read_i),
    .sample_valid_i (sample_valid_i),
    .accel_x_i      (accel_x_i),
    .accel_y_i      (accel_y_i),
    .accel_z_i      (accel_z_i),
    .vecm_event_o   (vecm_event_o)
  );

  always #25 ref_clk_i = ~ref_clk_i;

  // ========================================================================
  // Access tasks.
  task tick;
    @(posedge ref_clk_i);
    #5;
  endtask

  task wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick;
    reg_wr_i = 1'b0;
    tick;
  endtask

  task rd(input logic [6:0] a, input logic [7:0] e);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick;
    reg_rd_i = 1'b0;
    tick;
    `CHK(reg_rdata_o, e)
  endtask

  task smp(input accel_t x, input accel_t y, input accel_t z, input logic e);
    accel_x_i = x;
    accel_y_i = y;
    accel_z_i = z;
    sample_valid_i = 1'b1;
    tick;
    sample_valid_i = 1'b0;
    tick;
    `CHK(vecm_event_o, e)
  endtask

  task ack(input logic e);
    int_src_read_i = 1'b1;
    tick;
    int_src_read_i = 1'b0;
    tick;
    `CHK(vecm_event_o, e)
  endtask

  task done(input string n);
    $display("test %s finished, errors so far %0d", n, error_cnt);
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    error_cnt++;
    results;
  end

  // ========================================================================
  // Test sequence.
  initial begin
    ref_clk_i = 1'b0; reset_i = 1'b1; reg_addr_i = 7'h00; reg_wr_i = 1'b0;
    reg_wdata_i = 8'h00; reg_rd_i = 1'b0; int_src_read_i = 1'b0; sample_valid_i = 1'b0;
    accel_x_i = '0; accel_y_i = '0; accel_z_i = '0; error_cnt = 0; samples_checked = 0;
    repeat (20) tick;
    reset_i = 1'b0;
    tick;
    for (int a = 'h5F; a <= 'h68; a++) rd(a[6:0], 8'h00);
    rd(7'h70, 8'h00);
    smp(14'sd1000, 14'sd0, 14'sd0, 1'b0);
    done("reset");
    wr(`VM_ADDR_THS_HI, 8'hFF);
    rd(`VM_ADDR_THS_HI, 8'h9F);
    wr(`VM_ADDR_INITX_HI, 8'hFF);
    rd(`VM_ADDR_INITX_HI, 8'h3F);
    wr(`VM_ADDR_CFG, 8'hFF);
    rd(`VM_ADDR_CFG, 8'h78);
    wr(`VM_ADDR_CFG, 8'h00);
    wr(`VM_ADDR_THS_HI, 8'h00);
    wr(`VM_ADDR_INITX_HI, 8'h00);
    done("fields");
    wr(`VM_ADDR_THS_LO, 8'h05);
    wr(`VM_ADDR_CNT, 8'h02);
    rd(`VM_ADDR_CNT, 8'h02);
    wr(`VM_ADDR_CFG, 8'h38);
    smp(14'sd3, 14'sd4, 14'sd0, 1'b0);
    smp(14'sd3, 14'sd4, 14'sd1, 1'b0);
    smp(14'sd3, 14'sd4, 14'sd1, 1'b1);
    smp(14'sd0, 14'sd0, 14'sd0, 1'b0);
    smp(-14'sd3, 14'sd4, 14'sd1, 1'b1);
    done("debounce decrement");
    wr(`VM_ADDR_THS_HI, 8'h80);
    smp(14'sd0, 14'sd0, 14'sd6, 1'b1);
    smp(14'sd0, 14'sd0, 14'sd0, 1'b0);
    smp(14'sd0, 14'sd0, 14'sd6, 1'b0);
    smp(14'sd0, 14'sd0, 14'sd6, 1'b1);
    done("debounce clear");
    wr(`VM_ADDR_THS_HI, 8'h00);
    wr(`VM_ADDR_CNT, 8'h00);
    wr(`VM_ADDR_INITX_LO, 8'h64);
    smp(14'sd100, 14'sd0, 14'sd0, 1'b0);
    smp(14'sd0, 14'sd0, 14'sd0, 1'b1);
    done("live reference");
    wr(`VM_ADDR_CFG, 8'h00);
    accel_x_i = 14'sd50;
    wr(`VM_ADDR_CFG, 8'h08);
    smp(14'sd50, 14'sd0, 14'sd0, 1'b0);
    smp(14'sd60, 14'sd0, 14'sd0, 1'b1);
    smp(14'sd60, 14'sd0, 14'sd0, 1'b0);
    done("capture and update");
    wr(`VM_ADDR_CFG, 8'h00);
    accel_x_i = 14'sd50;
    wr(`VM_ADDR_CFG, 8'h18);
    smp(14'sd60, 14'sd0, 14'sd0, 1'b1);
    smp(14'sd60, 14'sd0, 14'sd0, 1'b1);
    done("fixed reference");
    wr(`VM_ADDR_CFG, 8'h00);
    wr(`VM_ADDR_CFG, 8'h28);
    smp(14'sd100, 14'sd0, 14'sd0, 1'b0);
    smp(14'sd0, 14'sd0, 14'sd0, 1'b1);
    smp(14'sd0, 14'sd0, 14'sd0, 1'b0);
    done("initial reference");
    wr(`VM_ADDR_CFG, 8'h00);
    accel_x_i = 14'sd50;
    wr(`VM_ADDR_CFG, 8'h58);
    ack(1'b0);
    smp(14'sd60, 14'sd0, 14'sd0, 1'b1);
    smp(14'sd50, 14'sd0, 14'sd0, 1'b1);
    ack(1'b0);
    smp(14'sd50, 14'sd0, 14'sd0, 1'b0);
    done("latch");
    results;
  end
endmodule
